/* core/lcdp_data_port.sv */
// Purpose: two-wire receive and read-back port of a multiplexed lcd driver
// Assumes: serialClockPin is the link clock and idles high between frames
// Notes: link logic uses both clock edges; display side runs on sys_clk
`timescale 1ns/10ps
`default_nettype none
module lcdp_data_port
  import lcdp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic serialClockPin,
  input wire logic dataLineIn,
  output logic dataLineOut,
  output logic dataLineOe,
  input wire logic latchEnableN,
  input wire logic [1:0] bpSelect,
  output logic [31:0] frontplane
);
  // ---------------- reset and pin synchronisers (sys_clk) ----------------
  logic [1:0] rstSync_reg;
  logic rstN;
  logic enbSync1_reg, enbSync2_reg, enbPrev_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync_reg <= 2'b00;
    end else begin
      rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
  end
  assign rstN = rstSync_reg[1];

  // pulse must be wide enough to survive two sys_clk flops
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      enbSync1_reg <= 1'b1;
      enbSync2_reg <= 1'b1;
      enbPrev_reg <= 1'b1;
    end else if (clkEn) begin
      enbSync1_reg <= latchEnableN;
      enbSync2_reg <= enbSync1_reg;
      enbPrev_reg <= enbSync2_reg;
    end
  end

  // ---------------- link side: start and stop detection ------------------
  logic startTog_reg, stopTog_reg;
  logic startSeen_reg, stopSeen_reg;
  logic startPend, stopPend;

  // data edges with the clock high; never while the device drives, since
  // the device only changes the line after a falling clock edge
  always_ff @(negedge dataLineIn or negedge rstN) begin
    if (!rstN) begin
      startTog_reg <= 1'b0;
    end else if (serialClockPin) begin
      startTog_reg <= ~startTog_reg;
    end
  end

  always_ff @(posedge dataLineIn or negedge rstN) begin
    if (!rstN) begin
      stopTog_reg <= 1'b0;
    end else if (serialClockPin) begin
      stopTog_reg <= ~stopTog_reg;
    end
  end

  // toggles are stable by the next clock edge, so they are read directly
  assign startPend = startTog_reg != startSeen_reg;
  assign stopPend = stopTog_reg != stopSeen_reg;

  // ---------------- link side: bit sequencing (rising clock) -------------
  lcdp_state_type state_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] rxByte_reg;
  logic [127:0] linkShift_reg;
  logic [3:0] byteCnt_reg;
  logic skipNext_reg, ackOk_reg, lastPushed_reg;
  logic takeBit, ackClock;
  logic fifoWrValid, fifoWrReady;
  lcdp_entry_type fifoWrEntry, fifoRdEntry;

  assign takeBit = !startPend && !stopPend && !skipNext_reg &&
                   state_reg != ST_IDLE && bitCnt_reg != LCDP_ACK_SLOT;
  assign ackClock = !startPend && !stopPend && !skipNext_reg &&
                    state_reg != ST_IDLE && bitCnt_reg == LCDP_ACK_SLOT;

  always_ff @(posedge serialClockPin or negedge rstN) begin
    if (!rstN) begin
      startSeen_reg <= 1'b0;
      stopSeen_reg <= 1'b0;
      state_reg <= ST_IDLE;
      bitCnt_reg <= 4'h0;
      skipNext_reg <= 1'b0;
    end else if (startPend) begin
      // this rising edge already carries the first address bit
      startSeen_reg <= startTog_reg;
      stopSeen_reg <= stopTog_reg;
      state_reg <= ST_ADDR;
      bitCnt_reg <= 4'h1;
      skipNext_reg <= 1'b0;
    end else if (stopPend) begin
      stopSeen_reg <= stopTog_reg;
      state_reg <= ST_IDLE;
      bitCnt_reg <= 4'h0;
      skipNext_reg <= 1'b0;
    end else if (skipNext_reg) begin
      skipNext_reg <= 1'b0;
    end else if (ackClock) begin
      bitCnt_reg <= 4'h0;
      if (state_reg == ST_ADDR) begin
        if (addrMatch(rxByte_reg)) begin
          state_reg <= rxByte_reg[0] ? ST_READ : ST_WRITE;
        end else begin
          state_reg <= ST_IDLE;
        end
      end
      if (state_reg == ST_WRITE) begin
        skipNext_reg <= lastPushed_reg;
      end
    end else if (takeBit) begin
      bitCnt_reg <= bitCnt_reg + 4'h1;
    end
  end

  always_ff @(posedge serialClockPin or negedge rstN) begin
    if (!rstN) begin
      rxByte_reg <= LCDP_BYTE_RST;
    end else if (startPend) begin
      rxByte_reg <= {7'h00, dataLineIn};
    end else if (takeBit) begin
      rxByte_reg <= {rxByte_reg[6:0], dataLineIn};
    end
  end

  // write takes whole accepted bytes only, so a stop's lead-in clock, a
  // cut byte or a refused byte never reaches read-back; read rotates
  always_ff @(posedge serialClockPin or negedge rstN) begin
    if (!rstN) begin
      linkShift_reg <= LCDP_SHIFT_RST;
    end else if (fifoWrValid && fifoWrReady) begin
      linkShift_reg <= {linkShift_reg[119:0], fifoWrEntry.data};
    end else if (takeBit && state_reg == ST_READ) begin
      linkShift_reg <= {linkShift_reg[126:0], linkShift_reg[127]};
    end
  end

  // a full fifo withholds the acknowledge, so the controller sees it
  assign fifoWrValid = takeBit && state_reg == ST_WRITE &&
                       bitCnt_reg == 4'h7;
  assign fifoWrEntry.lastOfBlock = byteCnt_reg == LCDP_LAST_BYTE;
  assign fifoWrEntry.data = {rxByte_reg[6:0], dataLineIn};

  always_ff @(posedge serialClockPin or negedge rstN) begin
    if (!rstN) begin
      byteCnt_reg <= 4'h0;
      ackOk_reg <= 1'b0;
      lastPushed_reg <= 1'b0;
    end else if (fifoWrValid) begin
      ackOk_reg <= fifoWrReady;
      lastPushed_reg <= fifoWrReady && fifoWrEntry.lastOfBlock;
      if (fifoWrReady) begin
        byteCnt_reg <= byteCnt_reg + 4'h1;
      end
    end
  end

  // ---------------- link side: line drive (falling clock) ---------------
  logic oe_reg;

  always_ff @(negedge serialClockPin or negedge rstN) begin
    if (!rstN) begin
      oe_reg <= 1'b0;
    end else if (startPend || stopPend) begin
      oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR:
          oe_reg <= bitCnt_reg == LCDP_ACK_SLOT &&
                    addrMatch(rxByte_reg);
        ST_WRITE:
          oe_reg <= bitCnt_reg == LCDP_ACK_SLOT && ackOk_reg;
        ST_READ:
          oe_reg <= bitCnt_reg != LCDP_ACK_SLOT &&
                    !linkShift_reg[127];
        default:
          oe_reg <= 1'b0;
      endcase
    end
  end

  // open drain: only ever pulls low
  assign dataLineOut = 1'b0;
  assign dataLineOe = oe_reg;

  // ---------------- byte fifo across the clock boundary ------------------
  logic fifoRdValid, fifoRdReady, rdFire, enbRise;

  lcdp_fifo #(
    .WIDTH($bits(lcdp_entry_type)),
    .DEPTH(LCDP_FIFO_DEPTH)
  ) u_fifo (
    .wrClk(serialClockPin),
    .wrRstN(rstN),
    .wrValid(fifoWrValid),
    .wrReady(fifoWrReady),
    .wrData(fifoWrEntry),
    .rdClk(sys_clk),
    .rdRstN(rstN),
    .rdClkEn(clkEn),
    .rdValid(fifoRdValid),
    .rdReady(fifoRdReady),
    .rdData(fifoRdEntry)
  );

  // ---------------- display side (sys_clk) -------------------------------
  logic [127:0] stage_reg, stage_next, display_reg;
  logic [31:0] frontplane_reg;

  // controller keeps the pulse inside clock-high, so no bit lands in it
  assign enbRise = enbSync2_reg && !enbPrev_reg;
  // drain stalls for the enable latch so the staged word stays put
  assign fifoRdReady = !enbRise;
  assign rdFire = fifoRdValid && fifoRdReady && clkEn;
  assign stage_next = {stage_reg[119:0], fifoRdEntry.data};

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      stage_reg <= LCDP_SHIFT_RST;
    end else if (rdFire) begin
      stage_reg <= stage_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      display_reg <= LCDP_SHIFT_RST;
    end else if (clkEn) begin
      if (enbRise) begin
        display_reg <= stage_reg;
      end else if (rdFire && fifoRdEntry.lastOfBlock && enbSync2_reg) begin
        display_reg <= stage_next;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      frontplane_reg <= LCDP_PLANE_RST;
    end else if (clkEn) begin
      frontplane_reg <= planeSlice(display_reg, bpSelect);
    end
  end
  assign frontplane = frontplane_reg;

  // ---------------- checks ----------------------------------------------
  property p_addr_ack;
    @(negedge serialClockPin) disable iff (!rstN)
    (state_reg == ST_ADDR && bitCnt_reg == LCDP_ACK_SLOT && !startPend &&
     !stopPend && rxByte_reg[7:1] == LCDP_DEV_ADDR) |=> dataLineOe;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("matching address not acknowledged");

  property p_addr_dir;
    @(posedge serialClockPin) disable iff (!rstN)
    (ackClock && state_reg == ST_ADDR && addrMatch(rxByte_reg))
      |=> state_reg == (rxByte_reg[0] ? ST_READ : ST_WRITE) &&
          bitCnt_reg == 4'h0;
  endproperty
  a_addr_dir: assert property (p_addr_dir)
    else $error("direction bit not honoured");

  property p_addr_miss;
    @(posedge serialClockPin) disable iff (!rstN)
    (ackClock && state_reg == ST_ADDR && !addrMatch(rxByte_reg))
      |=> state_reg == ST_IDLE;
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("foreign address took the channel");

  property p_write_ack;
    @(negedge serialClockPin) disable iff (!rstN)
    (state_reg == ST_WRITE && bitCnt_reg == LCDP_ACK_SLOT && ackOk_reg &&
     !startPend && !stopPend) |=> dataLineOe ##1 !dataLineOe;
  endproperty
  a_write_ack: assert property (p_write_ack)
    else $error("written byte not acknowledged for one clock");

  property p_read_release;
    @(negedge serialClockPin) disable iff (!rstN)
    (state_reg == ST_READ && bitCnt_reg == LCDP_ACK_SLOT) |=> !dataLineOe;
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("line not released after a read byte");

  property p_skip_edge;
    @(posedge serialClockPin) disable iff (!rstN)
    (skipNext_reg && !startPend && !stopPend)
      |=> $stable(linkShift_reg) && $stable(bitCnt_reg) && !skipNext_reg;
  endproperty
  a_skip_edge: assert property (p_skip_edge)
    else $error("edge after a full block was not ignored");

  property p_start;
    @(posedge serialClockPin) disable iff (!rstN)
    startPend |=> state_reg == ST_ADDR && bitCnt_reg == 4'h1 && !startPend;
  endproperty
  a_start: assert property (p_start)
    else $error("start did not open an address phase");

  property p_stop;
    @(posedge serialClockPin) disable iff (!rstN)
    (stopPend && !startPend) |=> state_reg == ST_IDLE ##1
      (state_reg == ST_IDLE || $past(startPend));
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not close the channel");

  property p_block_latch;
    @(posedge sys_clk) disable iff (!rstN)
    (rdFire && fifoRdEntry.lastOfBlock && enbSync2_reg && !enbRise)
      |=> display_reg == stage_reg ##1 frontplane_reg ==
          planeSlice(display_reg, $past(bpSelect) ) || !clkEn;
  endproperty
  a_block_latch: assert property (p_block_latch)
    else $error("full block not latched for display");

  property p_enb_latch;
    @(posedge sys_clk) disable iff (!rstN)
    (enbRise && clkEn) |=> display_reg == $past(stage_reg) &&
      $stable(stage_reg);
  endproperty
  a_enb_latch: assert property (p_enb_latch)
    else $error("enable pulse did not latch the staged data");

  property p_plane;
    @(posedge sys_clk) disable iff (!rstN)
    clkEn |=> frontplane == planeSlice($past(display_reg), $past(bpSelect));
  endproperty
  a_plane: assert property (p_plane)
    else $error("frontplane block does not follow the backplane");
endmodule
`default_nettype wire

/* core/lcdp_fifo.sv */
// Purpose: dual-clock fifo carrying bytes from the link to the display side
// Assumes: DEPTH is a power of two; both resets assert together
// Notes: gray pointers cross through two flops each way
`timescale 1ns/10ps
`default_nettype none
module lcdp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic wrClk,
  input wire logic wrRstN,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic rdClk,
  input wire logic rdRstN,
  input wire logic rdClkEn,
  output logic rdValid,
  input wire logic rdReady,
  output logic [WIDTH-1:0] rdData
);
  localparam int AW = $clog2(DEPTH);

  function automatic logic [AW:0] toGray(input logic [AW:0] bin);
    return bin ^ (bin >> 1);
  endfunction

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wrBin_reg, wrGray_reg, rdBin_reg, rdGray_reg;
  logic [AW:0] rdGrayW1_reg, rdGrayW2_reg, wrGrayR1_reg, wrGrayR2_reg;
  logic [AW:0] wrBin_next, rdBin_next;
  logic wrFire, rdFire;

  // full when pointers differ only in their two top gray bits
  assign wrReady = wrGray_reg !=
    {~rdGrayW2_reg[AW:AW-1], rdGrayW2_reg[AW-2:0]};
  assign rdValid = rdGray_reg != wrGrayR2_reg;
  assign wrFire = wrValid && wrReady;
  assign rdFire = rdValid && rdReady && rdClkEn;
  assign wrBin_next = wrBin_reg + 1'b1;
  assign rdBin_next = rdBin_reg + 1'b1;
  assign rdData = mem_reg[rdBin_reg[AW-1:0]];

  always_ff @(posedge wrClk) begin
    if (wrFire) begin
      mem_reg[wrBin_reg[AW-1:0]] <= wrData;
    end
  end

  always_ff @(posedge wrClk or negedge wrRstN) begin
    if (!wrRstN) begin
      wrBin_reg <= '0;
      wrGray_reg <= '0;
    end else if (wrFire) begin
      wrBin_reg <= wrBin_next;
      wrGray_reg <= toGray(wrBin_next);
    end
  end

  // link clock may stop; a stale read pointer only looks fuller
  always_ff @(posedge wrClk or negedge wrRstN) begin
    if (!wrRstN) begin
      rdGrayW1_reg <= '0;
      rdGrayW2_reg <= '0;
    end else begin
      rdGrayW1_reg <= rdGray_reg;
      rdGrayW2_reg <= rdGrayW1_reg;
    end
  end

  always_ff @(posedge rdClk or negedge rdRstN) begin
    if (!rdRstN) begin
      rdBin_reg <= '0;
      rdGray_reg <= '0;
    end else if (rdFire) begin
      rdBin_reg <= rdBin_next;
      rdGray_reg <= toGray(rdBin_next);
    end
  end

  always_ff @(posedge rdClk or negedge rdRstN) begin
    if (!rdRstN) begin
      wrGrayR1_reg <= '0;
      wrGrayR2_reg <= '0;
    end else if (rdClkEn) begin
      wrGrayR1_reg <= wrGray_reg;
      wrGrayR2_reg <= wrGrayR1_reg;
    end
  end
endmodule
`default_nettype wire

/* shared/lcdp_pkg.sv */
// Purpose: shared constants, types and helpers of the lcd data port
// Assumes: one byte-wide path from the serial link to the display side
// Notes:
package lcdp_pkg;
  localparam logic [6:0] LCDP_DEV_ADDR = 7'h3F;
  localparam int LCDP_BLOCK_BITS = 128;
  localparam int LCDP_PLANE_BITS = 32;
  localparam int LCDP_FIFO_DEPTH = 16;
  localparam logic [3:0] LCDP_ACK_SLOT = 4'h8;
  localparam logic [3:0] LCDP_LAST_BYTE = 4'hF;
  localparam logic [127:0] LCDP_SHIFT_RST = 128'h0;
  localparam logic [31:0] LCDP_PLANE_RST = 32'h0;
  localparam logic [7:0] LCDP_BYTE_RST = 8'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_WRITE = 2'b11,
    ST_READ = 2'b10
  } lcdp_state_type;

  typedef struct packed {
    logic lastOfBlock;
    logic [7:0] data;
  } lcdp_entry_type;

  function automatic logic addrMatch(input logic [7:0] addrByte);
    return addrByte[7:1] == LCDP_DEV_ADDR;
  endfunction

  // block 0 is the oldest 32 bits received
  function automatic logic [31:0] planeSlice(input logic [127:0] word,
                                             input logic [1:0] plane);
    logic [31:0] slice;
    slice = LCDP_PLANE_RST;
    case (plane)
      2'h0: slice = word[127:96];
      2'h1: slice = word[95:64];
      2'h2: slice = word[63:32];
      default: slice = word[31:0];
    endcase
    return slice;
  endfunction
endpackage

/* verif/lcdp_ctrl_model.sv */
// Purpose: behavioural two-wire bus controller for the lcd data port bench
// Assumes: data line has a pull-up; the device only ever pulls it low
// Notes: clock rests high between frames, so it stands still outside them
`timescale 1ns/10ps
`default_nettype none
module lcdp_ctrl_model (
  output logic sclk,
  output logic pullLow,
  input wire logic wireLevel
);
  logic inFrame;

  initial begin
    sclk = 1'b1;
    pullLow = 1'b0;
    inFrame = 1'b0;
  end

  // one 6 ns pulse; data moves only in the low phase, sampled at the rise
  task automatic pulse(input logic b, output logic seen);
    sclk = 1'b0;
    #1.5;
    pullLow = !b;
    #1.5;
    seen = wireLevel;
    sclk = 1'b1;
    #3;
  endtask

  task automatic start();
    if (inFrame) begin
      sclk = 1'b0;
      #1.5;
      pullLow = 1'b0;
      #1.5;
      sclk = 1'b1;
      #3;
    end
    pullLow = 1'b1;
    #6;
    inFrame = 1'b1;
  endtask

  task automatic stop();
    sclk = 1'b0;
    #1.5;
    pullLow = 1'b1;
    #1.5;
    sclk = 1'b1;
    #3;
    pullLow = 1'b0;
    #6;
    inFrame = 1'b0;
  endtask

  task automatic sendBits(input logic [7:0] v, input int n);
    logic s;
    for (int i = 0; i < n; i++) begin
      pulse(v[7-i], s);
    end
  endtask

  // long low rest after each byte keeps the link slower than the drain
  task automatic writeByte(input logic [7:0] v, output logic ack);
    logic s;
    sendBits(v, 8);
    pulse(1'b1, s);
    ack = !s;
    sclk = 1'b0;
    #150;
  endtask

  // ninth pulse left released: this controller never acks read data
  task automatic readByte(output logic [7:0] v, output logic ninth);
    logic s;
    for (int i = 0; i < 8; i++) begin
      pulse(1'b1, s);
      v[7-i] = s;
    end
    pulse(1'b1, ninth);
  endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// Purpose: self-checking bench of the lcd data port
// Assumes: controller model drives the link; bench owns sys_clk side pins
// Notes: expected display kept in a bit-level model of the shift register
`timescale 1ns/10ps
`default_nettype none
module tb
  import lcdp_pkg::*;
;
  logic sys_clk;
  logic arst_n;
  logic clkEn;
  logic latchEnableN;
  logic [1:0] bpSelect;
  logic [31:0] frontplane;
  logic dataLineOut;
  logic dataLineOe;
  logic sclk;
  logic pullLow;
  logic wireLevel;
  logic [127:0] shiftModel;
  logic [127:0] dispModel;
  logic ack;
  logic s;
  logic [7:0] b;
  int byteCount;
  int miscompares;
  int n_tests;

  // open drain wire with pull-up
  assign wireLevel = (dataLineOe ? dataLineOut : 1'b1) & !pullLow;

  lcdp_data_port dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn),
    .serialClockPin(sclk), .dataLineIn(wireLevel),
    .dataLineOut(dataLineOut), .dataLineOe(dataLineOe),
    .latchEnableN(latchEnableN), .bpSelect(bpSelect),
    .frontplane(frontplane)
  );
  lcdp_ctrl_model ctrl (.sclk(sclk), .pullLow(pullLow), .wireLevel(wireLevel));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = !sys_clk;
  end

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [127:0] exp,
                       input logic [127:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // latch lags the link by the fifo drain, so wait on plane 0 first
  task automatic checkPlanes(input logic [127:0] exp);
    int k;
    tick();
    bpSelect = 2'h0;
    tick();
    tick();
    k = 0;
    while (frontplane !== exp[127:96] && k < 60) begin
      tick();
      k++;
    end
    if (k == 60) begin
      miscompares++;
      $display("MISMATCH latch wait expected %h seen %h", exp[127:96],
               frontplane);
      end_of_test();
    end
    for (int p = 0; p < 4; p++) begin
      bpSelect = 2'(p);
      tick();
      tick();
      check("frontplane", exp[127-32*p -: 32], frontplane);
    end
  endtask

  task automatic frameStart(input logic [7:0] a, input logic expAck);
    ctrl.start();
    ctrl.writeByte(a, ack);
    check("address ack", expAck, ack);
  endtask

  task automatic writeBlock(input int n, input int nAck);
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom());
      ctrl.writeByte(b, ack);
      check("data ack", i < nAck, ack);
      if (i < nAck) begin
        shiftModel = {shiftModel[119:0], b};
        byteCount++;
        if (byteCount % (LCDP_BLOCK_BITS / 8) == 0 && latchEnableN) begin
          dispModel = shiftModel;
        end
        if (byteCount % (LCDP_BLOCK_BITS / 8) == 0 && i < n - 1) begin
          ctrl.pulse(1'b1, s);
        end
      end
    end
  endtask

  initial begin
    arst_n = 1'b0;
    clkEn = 1'b1;
    latchEnableN = 1'b1;
    bpSelect = 2'h0;
    shiftModel = LCDP_SHIFT_RST;
    dispModel = LCDP_SHIFT_RST;
    byteCount = 0;
    miscompares = 0;
    n_tests = 0;
    repeat (3) tick();
    arst_n = 1'b1;
    repeat (4) tick();
    void'($urandom(51364));
    check("idle oe", 1'b0, dataLineOe);
    check("line out", 1'b0, dataLineOut);
    checkPlanes(dispModel);
    b = 8'($urandom());
    if (b[7:1] == LCDP_DEV_ADDR) begin
      b[7] = !b[7];
    end
    frameStart(b, 1'b0);
    ctrl.stop();
    frameStart({LCDP_DEV_ADDR, 1'b0}, 1'b1);
    writeBlock(32, 32);
    ctrl.stop();
    checkPlanes(dispModel);
    frameStart({LCDP_DEV_ADDR, 1'b0}, 1'b1);
    writeBlock(4, 4);
    frameStart({LCDP_DEV_ADDR, 1'b0}, 1'b1);
    ctrl.sendBits(8'($urandom()), 3);
    ctrl.stop();
    // a closed channel must ignore a whole byte and its ninth clock
    ctrl.writeByte(8'($urandom()), ack);
    check("closed ack", 1'b0, ack);
    ctrl.stop();
    frameStart({LCDP_DEV_ADDR, 1'b0}, 1'b1);
    writeBlock(12, 12);
    ctrl.stop();
    checkPlanes(dispModel);
    frameStart({LCDP_DEV_ADDR, 1'b1}, 1'b1);
    for (int i = 0; i < 17; i++) begin
      ctrl.readByte(b, s);
      check("read byte", shiftModel[127-8*(i%16) -: 8], b);
      check("read ninth", 1'b1, s);
    end
    // stop only in the released ninth slot; a low data bit would block it
    ctrl.sendBits(8'hFF, 8);
    ctrl.stop();
    tick();
    clkEn = 1'b0;
    frameStart({LCDP_DEV_ADDR, 1'b0}, 1'b1);
    writeBlock(17, 16);
    ctrl.stop();
    tick();
    clkEn = 1'b1;
    checkPlanes(dispModel);
    latchEnableN = 1'b0;
    frameStart({LCDP_DEV_ADDR, 1'b0}, 1'b1);
    writeBlock(16, 16);
    ctrl.stop();
    repeat (30) tick();
    checkPlanes(dispModel);
    // pulse only while the link clock rests high after the stop
    latchEnableN = 1'b1;
    repeat (3) tick();
    latchEnableN = 1'b0;
    dispModel = shiftModel;
    checkPlanes(dispModel);
    end_of_test();
  end
endmodule
`default_nettype wire
